/* File: rtl/spc_config.sv */
// What this block does
// - Activation register at 30h, resets 00h, qualified by two global bits
// - Base high resets 03h; bits 7..3 read zero, read-only
// - Base low resets F8h; bits 2..0 read zero, eight-byte aligned
// - Interrupt select and wake enable register at 70h, resets 04h
// - Interrupt type at 71h resets 03h; only bit 1 writable
// - Both DMA report indexes read 04h always, read-only
// - Port config register at F0h, read/write, resets 02h
// - Config bit 7 enables bank switching; clear by default
// - Config bit 2 reads busy while a serial transfer runs
// - Power bit 0 while active: clock stopped, outputs at defaults
// - In low power the ring input can still raise an interrupt
// - Low power keeps registers accessible; only deactivation blocks them
// - Power bit 1 while active: clock runs, port fully operates
// - Float bit set and device inactive: outputs high impedance
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module spc_config
  import spc_pkg::*;
#(
  parameter int           PIN_W       = 4,
  parameter logic [PIN_W-1:0] PIN_DEFAULT = '1
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Serial core status
  input  wire logic             core_tx_busy_i,
  input  wire logic             core_rx_busy_i,
  input  wire logic             ext_bank_req_i,
  // Serial core and pins
  input  wire logic [PIN_W-1:0] core_out_i,
  input  wire logic             ring_indicator_input_i,
  output logic      [PIN_W-1:0] pin_out_o,
  output logic      [PIN_W-1:0] pin_oe_o,
  // Controls toward the serial core
  output logic                  port_clk_en_o,
  output logic                  port_regs_access_o,
  output logic                  ext_bank_grant_o,
  output logic      [15:0]      base_addr_o,
  output logic      [7:0]       irq_select_o,
  output logic      [7:0]       irq_kind_o,
  // Interrupt
  output logic                  ring_wake_o,
  output logic                  irq_o
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [7:0]           port_activate_reg;
  logic [7:0]           base_addr_high_reg;
  logic [7:0]           base_addr_low_reg;
  logic [7:0]           irq_select_wake_reg;
  logic [7:0]           irq_kind_reg;
  logic [7:0]           port_config_reg;
  logic [7:0]           global_ctrl_reg;
  logic [EVT_COUNT-1:0] event_status_reg;
  logic [EVT_COUNT-1:0] event_mask_reg;
  logic [31:0]          prdata_reg;
  logic                 slverr_reg;
  logic                 busy_reg;
  logic                 ring_prev_reg;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic [7:0] acc_index;
  logic       acc_ok;
  logic       wr_stb;
  logic       setup_stb;
  logic [7:0] wr_byte;

  // Index is the word address; low address bits must be zero
  function automatic logic index_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) begin
      return 1'b0;
    end
    unique case (idx)
      IDX_PORT_ACTIVATE, IDX_BASE_HIGH, IDX_BASE_LOW, IDX_IRQ_SELECT,
      IDX_IRQ_KIND, IDX_DMA_REPORT_A, IDX_DMA_REPORT_B, IDX_PORT_CONFIG,
      IDX_GLOBAL_CTRL, IDX_EVENT_STATUS, IDX_EVENT_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : index_mapped

  // Merge writable bits of a byte, keep the fixed ones
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] wmask);
    return (old_v & ~wmask) | (new_v & wmask);
  endfunction : merge

  assign acc_index = paddr[9:2];
  assign acc_ok    = index_mapped(paddr);
  assign setup_stb = psel & ~penable;
  // Write lands at the access edge, only for mapped addresses
  assign wr_stb    = psel & penable & pwrite & acc_ok;
  assign wr_byte   = pwdata[7:0];

  // ------------------------------------------------------------------
  // Derived device state
  // ------------------------------------------------------------------
  logic active_eff;
  logic low_power;
  logic ring_lvl;
  logic busy_now;

  // Activation counts only with both global enables set
  assign active_eff = port_activate_reg[BIT_ACTIVE]
                    & global_ctrl_reg[BIT_GLOBAL_ONE]
                    & global_ctrl_reg[BIT_GLOBAL_SIX];
  assign low_power  = active_eff & ~port_config_reg[BIT_POWER_NORMAL];
  // Either transmitter or receiver busy means a transfer runs
  assign busy_now   = core_tx_busy_i | core_rx_busy_i;

  // ------------------------------------------------------------------
  // Ring input filter
  // ------------------------------------------------------------------
  spc_pin_sync #(
    .W         (1)
  ) u_ring_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (ring_indicator_input_i),
    .level_o   (ring_lvl)
  );

  // ------------------------------------------------------------------
  // Activation register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_activate_reg <= RST_PORT_ACTIVATE;
    end else if (wr_stb && acc_index == IDX_PORT_ACTIVATE) begin
      port_activate_reg <= wr_byte;
    end
  end

  // ------------------------------------------------------------------
  // Base address pair
  // ------------------------------------------------------------------
  // Fixed bits stay as reset, so the window remains eight-byte aligned
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_addr_high_reg <= RST_BASE_HIGH;
      base_addr_low_reg  <= RST_BASE_LOW;
    end else if (wr_stb) begin
      if (acc_index == IDX_BASE_HIGH) begin
        base_addr_high_reg <= merge(base_addr_high_reg, wr_byte,
                                    WR_BASE_HIGH);
      end
      if (acc_index == IDX_BASE_LOW) begin
        base_addr_low_reg <= merge(base_addr_low_reg, wr_byte,
                                   WR_BASE_LOW);
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt number and type
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_select_wake_reg <= RST_IRQ_SELECT;
      irq_kind_reg        <= RST_IRQ_KIND;
    end else if (wr_stb) begin
      if (acc_index == IDX_IRQ_SELECT) begin
        irq_select_wake_reg <= wr_byte;
      end
      if (acc_index == IDX_IRQ_KIND) begin
        irq_kind_reg <= merge(irq_kind_reg, wr_byte, WR_IRQ_KIND);
      end
    end
  end

  // ------------------------------------------------------------------
  // Port configuration register
  // ------------------------------------------------------------------
  // Busy and reserved bits are not stored; the mask drops them
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_config_reg <= RST_PORT_CONFIG;
    end else if (wr_stb && acc_index == IDX_PORT_CONFIG) begin
      port_config_reg <= merge(port_config_reg, wr_byte,
                               WR_PORT_CONFIG);
    end
  end

  // ------------------------------------------------------------------
  // Global enables
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      global_ctrl_reg <= RST_GLOBAL_CTRL;
    end else if (wr_stb && acc_index == IDX_GLOBAL_CTRL) begin
      global_ctrl_reg <= merge(global_ctrl_reg, wr_byte, WR_GLOBAL_CTRL);
    end
  end

  // ------------------------------------------------------------------
  // Busy flag and ring edge history
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_reg      <= 1'b0;
      ring_prev_reg <= 1'b0;
    end else begin
      busy_reg      <= busy_now;
      ring_prev_reg <= ring_lvl;
    end
  end

  // ------------------------------------------------------------------
  // Events
  // ------------------------------------------------------------------
  logic [EVT_COUNT-1:0] evt_set;
  logic [EVT_COUNT-1:0] evt_clr;
  logic                 ring_edge;

  // Ring input is watched even with the port clock stopped
  assign ring_edge  = ring_lvl & ~ring_prev_reg;
  assign ring_wake_o = low_power & ring_edge
                     & irq_select_wake_reg[BIT_WAKE_EN];

  always_comb begin
    evt_set                  = '0;
    evt_set[EVT_RING]        = ring_wake_o;
    // Tells power software the port went idle
    evt_set[EVT_IDLE]        = busy_reg & ~busy_now;
    evt_set[EVT_BANK_DENIED] = ext_bank_req_i & active_eff
                             & ~port_config_reg[BIT_BANK_EN];
  end

  assign evt_clr = (wr_stb && acc_index == IDX_EVENT_STATUS)
                 ? wr_byte[EVT_COUNT-1:0] : '0;

  // Sticky bits, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_status_reg <= RST_EVENT_STATUS[EVT_COUNT-1:0];
    end else begin
      event_status_reg <= (event_status_reg & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_mask_reg <= RST_EVENT_MASK[EVT_COUNT-1:0];
    end else if (wr_stb && acc_index == IDX_EVENT_MASK) begin
      event_mask_reg <= wr_byte[EVT_COUNT-1:0];
    end
  end

  assign irq_o = |(event_status_reg & event_mask_reg);

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    unique case (acc_index)
      IDX_PORT_ACTIVATE: rd_byte = port_activate_reg;
      IDX_BASE_HIGH:     rd_byte = base_addr_high_reg
                                 & WR_BASE_HIGH;
      IDX_BASE_LOW:      rd_byte = base_addr_low_reg
                                 & WR_BASE_LOW;
      IDX_IRQ_SELECT:    rd_byte = irq_select_wake_reg;
      IDX_IRQ_KIND:      rd_byte = irq_kind_reg;
      IDX_DMA_REPORT_A:  rd_byte = VAL_NO_DMA;
      IDX_DMA_REPORT_B:  rd_byte = VAL_NO_DMA;
      IDX_PORT_CONFIG: begin
        rd_byte           = port_config_reg & WR_PORT_CONFIG;
        rd_byte[BIT_BUSY] = busy_reg;
      end
      IDX_GLOBAL_CTRL:   rd_byte = global_ctrl_reg;
      IDX_EVENT_STATUS:  rd_byte = {{(8-EVT_COUNT){1'b0}},
                                    event_status_reg};
      IDX_EVENT_MASK:    rd_byte = {{(8-EVT_COUNT){1'b0}},
                                    event_mask_reg};
      default:           rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------------
  // Read data is caught in the setup cycle so prdata comes from a flop;
  // this costs nothing since the access phase always takes one cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup_stb) begin
      prdata_reg <= (acc_ok && !pwrite) ? {24'h00_0000, rd_byte}
                                        : 32'h0000_0000;
      slverr_reg <= ~acc_ok;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & slverr_reg;

  // ------------------------------------------------------------------
  // Controls toward the serial core
  // ------------------------------------------------------------------
  // Clock runs only when active in normal power mode
  assign port_clk_en_o      = active_eff
                            & port_config_reg[BIT_POWER_NORMAL];
  // Power mode leaves the port registers reachable
  assign port_regs_access_o = active_eff;
  // Extended banks stay shut while bank switching is off
  assign ext_bank_grant_o   = ext_bank_req_i & active_eff
                            & port_config_reg[BIT_BANK_EN];
  assign base_addr_o        = {base_addr_high_reg & WR_BASE_HIGH,
                               base_addr_low_reg & WR_BASE_LOW};
  assign irq_select_o       = irq_select_wake_reg;
  assign irq_kind_o         = irq_kind_reg;

  // ------------------------------------------------------------------
  // Output pin control
  // ------------------------------------------------------------------
  logic hold_default;
  logic float_pins;

  // Inactive port without float also sits at its default levels
  assign hold_default = low_power | ~active_eff;
  assign float_pins   = ~active_eff
                      & port_config_reg[BIT_FLOAT_EN];

  spc_pin_gate #(
    .W              (PIN_W),
    .DEFAULT_OUT    (PIN_DEFAULT)
  ) u_pin_gate (
    .hold_default_i (hold_default),
    .float_i        (float_pins),
    .core_out_i     (core_out_i),
    .pin_out_o      (pin_out_o),
    .pin_oe_o       (pin_oe_o)
  );

endmodule : spc_config

/* File: rtl/spc_pkg.sv */
package spc_pkg;

  // ------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_ACTIVATE  = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH      = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW       = 8'h61;
  localparam logic [7:0] IDX_IRQ_SELECT     = 8'h70;
  localparam logic [7:0] IDX_IRQ_KIND       = 8'h71;
  localparam logic [7:0] IDX_DMA_REPORT_A   = 8'h74;
  localparam logic [7:0] IDX_DMA_REPORT_B   = 8'h75;
  localparam logic [7:0] IDX_PORT_CONFIG    = 8'hf0;
  localparam logic [7:0] IDX_GLOBAL_CTRL    = 8'he0;
  localparam logic [7:0] IDX_EVENT_STATUS   = 8'he1;
  localparam logic [7:0] IDX_EVENT_MASK     = 8'he2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_PORT_ACTIVATE  = 8'h00;
  localparam logic [7:0] RST_BASE_HIGH      = 8'h03;
  localparam logic [7:0] RST_BASE_LOW       = 8'hf8;
  localparam logic [7:0] RST_IRQ_SELECT     = 8'h04;
  localparam logic [7:0] RST_IRQ_KIND       = 8'h03;
  localparam logic [7:0] VAL_NO_DMA         = 8'h04;
  localparam logic [7:0] RST_PORT_CONFIG    = 8'h02;
  localparam logic [7:0] RST_GLOBAL_CTRL    = 8'h03;
  localparam logic [7:0] RST_EVENT_STATUS   = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK     = 8'h00;

  // ------------------------------------------------------------------
  // Writable bit masks and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] WR_BASE_HIGH       = 8'h07;
  localparam logic [7:0] WR_BASE_LOW        = 8'hf8;
  localparam logic [7:0] WR_IRQ_KIND        = 8'h02;
  localparam logic [7:0] WR_PORT_CONFIG     = 8'h83;
  localparam logic [7:0] WR_GLOBAL_CTRL     = 8'h03;
  localparam int         BIT_ACTIVE         = 0;
  localparam int         BIT_BANK_EN        = 7;
  localparam int         BIT_BUSY           = 2;
  localparam int         BIT_POWER_NORMAL   = 1;
  localparam int         BIT_FLOAT_EN       = 0;
  localparam int         BIT_GLOBAL_ONE     = 0;
  localparam int         BIT_GLOBAL_SIX     = 1;
  localparam int         BIT_WAKE_EN        = 4;

  // Event status bit positions
  localparam int         EVT_RING           = 0;
  localparam int         EVT_IDLE           = 1;
  localparam int         EVT_BANK_DENIED    = 2;
  localparam int         EVT_COUNT          = 3;

endpackage : spc_pkg

/* File: rtl/spc_pin_sync.sv */
`timescale 1ns/1ps
module spc_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  // Raw and filtered levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ------------------------------------------------------------------
  // Three stage capture; a change counts once stages two and three agree
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_reg[g]  <= 1'b0;
          s2_reg[g]  <= 1'b0;
          s3_reg[g]  <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          s1_reg[g] <= async_i[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            level_o[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate

endmodule : spc_pin_sync

/* File: rtl/spc_pin_gate.sv */
`timescale 1ns/1ps
module spc_pin_gate #(
  parameter int          W           = 4,
  parameter logic [W-1:0] DEFAULT_OUT = '1
) (
  // Mode
  input  wire logic         hold_default_i,
  input  wire logic         float_i,
  // Core side and pin side
  input  wire logic [W-1:0] core_out_i,
  output logic      [W-1:0] pin_out_o,
  output logic      [W-1:0] pin_oe_o
);

  // ------------------------------------------------------------------
  // Per pin: default level when held, released when floating
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      assign pin_out_o[g] = hold_default_i ? DEFAULT_OUT[g] : core_out_i[g];
      assign pin_oe_o[g]  = ~float_i;
    end
  endgenerate

endmodule : spc_pin_gate

/* File: tb/spc_config_props.sv */
`timescale 1ns/1ps
module spc_config_props
  import spc_pkg::*;
#(
  parameter int               PIN_W       = 4,
  parameter logic [PIN_W-1:0] PIN_DEFAULT = '1
) (
  // Clock and reset
  input wire logic             clk_sys_i,
  input wire logic             reset_n_i,
  // Bus
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  // Port controls
  input wire logic             port_clk_en_o,
  input wire logic             port_regs_access_o,
  input wire logic             ext_bank_req_i,
  input wire logic             ext_bank_grant_o,
  input wire logic [15:0]      base_addr_o,
  input wire logic [7:0]       irq_select_o,
  input wire logic [7:0]       irq_kind_o,
  input wire logic             ring_wake_o,
  // Pins
  input wire logic [PIN_W-1:0] core_out_i,
  input wire logic [PIN_W-1:0] pin_out_o,
  input wire logic [PIN_W-1:0] pin_oe_o
);
  // Single clock domain, so one default clocking serves all
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_pulse;
    ring_wake_o ##1 !ring_wake_o;
  endsequence
  a_zero_wait: assert property (s_access |-> pready)
    else $error("access cycle without ready");
  a_err_in_access: assert property (pslverr |-> s_access)
    else $error("error flag outside an access");
  a_clock_needs_act: assert property (port_clk_en_o |-> port_regs_access_o)
    else $error("port clock runs while inactive");
  a_pins_follow: assert property (port_clk_en_o |->
    pin_out_o == core_out_i && pin_oe_o == '1)
    else $error("pins do not follow the core");
  a_pins_default: assert property (!port_clk_en_o && pin_oe_o[0] |->
    pin_out_o == PIN_DEFAULT)
    else $error("stopped port pins not at default");
  a_float_inactive: assert property (pin_oe_o != '1 |->
    pin_oe_o == '0 && !port_regs_access_o)
    else $error("pins float while active");
  a_grant_gate: assert property (ext_bank_grant_o |->
    ext_bank_req_i && port_regs_access_o)
    else $error("bank grant without request or activation");
  a_base_align: assert property (base_addr_o[2:0] == 3'h0 &&
    base_addr_o[15:11] == 5'h00)
    else $error("base address read-only bits not zero");
  a_kind_fixed: assert property (irq_kind_o[7:2] == 6'h00 && irq_kind_o[0])
    else $error("interrupt type read-only bits changed");
  a_wake_pulse: assert property (ring_wake_o |->
    irq_select_o[BIT_WAKE_EN] && !port_clk_en_o ##0 s_pulse)
    else $error("ring wake pulse out of low power or too long");
endmodule : spc_config_props
bind spc_config spc_config_props #(.PIN_W(PIN_W), .PIN_DEFAULT(PIN_DEFAULT))
  spc_config_props_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .port_clk_en_o(port_clk_en_o), .port_regs_access_o(port_regs_access_o),
    .ext_bank_req_i(ext_bank_req_i), .ext_bank_grant_o(ext_bank_grant_o),
    .base_addr_o(base_addr_o), .irq_select_o(irq_select_o),
    .irq_kind_o(irq_kind_o), .ring_wake_o(ring_wake_o),
    .core_out_i(core_out_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o)
  );

/* File: tb/test_serial_port_one_config.sv */
`timescale 1ns/1ps
module test_serial_port_one_config;
  import spc_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk_sys_i = 0, reset_n_i = 0, psel = 0, penable = 0;
  logic        pwrite = 0, core_tx_busy_i = 0, core_rx_busy_i = 0;
  logic        ext_bank_req_i = 0, ring_indicator_input_i = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  core_out_i = 4'h5, pin_out_o, pin_oe_o;
  logic        pready, pslverr, er, port_clk_en_o, port_regs_access_o;
  logic        ext_bank_grant_o, ring_wake_o, irq_o;
  logic [15:0] base_addr_o;
  logic [7:0]  irq_select_o, irq_kind_o;
  int          miscompares = 0, checks_done = 0;
  // Rows: index, reset value, write value, value read back
  logic [31:0] rows [10] = '{32'h30000101, 32'h6003ff07, 32'h61f80f08,
    32'h70040505, 32'h71030001, 32'h74040004, 32'h75040004,
    32'hf002ff83, 32'he0030303, 32'he2000505};
  spc_config spc_config_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_tx_busy_i(core_tx_busy_i), .core_rx_busy_i(core_rx_busy_i),
    .ext_bank_req_i(ext_bank_req_i), .core_out_i(core_out_i),
    .ring_indicator_input_i(ring_indicator_input_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .port_clk_en_o(port_clk_en_o), .port_regs_access_o(port_regs_access_o),
    .ext_bank_grant_o(ext_bank_grant_o), .base_addr_o(base_addr_o),
    .irq_select_o(irq_select_o), .irq_kind_o(irq_kind_o),
    .ring_wake_o(ring_wake_o), .irq_o(irq_o)
  );
  always #12.5 clk_sys_i = ~clk_sys_i;
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  // Ends on a falling edge so register updates have landed before checks
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys_i);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdchk
  task automatic do_reset;
    // Assert on a rising edge like every other input
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(negedge clk_sys_i);
  endtask : do_reset
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // ------------------------------------------------------------------
  // Watchdog, far beyond the few microseconds the tests need
  // ------------------------------------------------------------------
  initial begin
    #100us;
    miscompares++;
    close_out();
  end
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      rdchk(rows[i][31:24], rows[i][23:16]);
      apb(1'b1, rows[i][31:24], rows[i][15:8]);
      rdchk(rows[i][31:24], rows[i][7:0]);
    end
    chk(base_addr_o, 16'h0708);
    chk(irq_kind_o, 8'h01);
    apb(1'b0, 8'h31, 8'h00);
    chk({rd[30:0], er}, 32'h1);
    $display("register table test done");
    // Reset in mid-run brings back defaults, pins driven
    do_reset();
    chk(pin_oe_o, 4'hf);
    chk(pin_out_o, 4'hf);
    rdchk(IDX_PORT_CONFIG, 8'h02);
    apb(1'b1, IDX_PORT_ACTIVATE, 8'h01);
    chk(port_clk_en_o, 1'b1);
    chk(pin_out_o, 4'h5);
    apb(1'b1, IDX_GLOBAL_CTRL, 8'h02);
    chk(port_regs_access_o, 1'b0);
    apb(1'b1, IDX_GLOBAL_CTRL, 8'h03);
    $display("activation test done");
    // Low power keeps registers reachable
    apb(1'b1, IDX_PORT_CONFIG, 8'h00);
    chk({port_clk_en_o, pin_out_o}, 5'h0f);
    chk(port_regs_access_o, 1'b1);
    rdchk(IDX_BASE_HIGH, 8'h03);
    // Ring wakes in low power; status is masked, then unmasked, cleared
    apb(1'b1, IDX_IRQ_SELECT, 8'h10);
    chk(irq_select_o, 8'h10);
    @(posedge clk_sys_i);
    ring_indicator_input_i <= 1'b1;
    repeat (8) @(negedge clk_sys_i);
    rdchk(IDX_EVENT_STATUS, 8'h01);
    chk(irq_o, 1'b0);
    apb(1'b1, IDX_EVENT_MASK, 8'h01);
    chk(irq_o, 1'b1);
    apb(1'b1, IDX_EVENT_STATUS, 8'h01);
    chk(irq_o, 1'b0);
    $display("ring wake test done");
    // Busy flag follows core activity and its end raises an event
    @(posedge clk_sys_i);
    core_tx_busy_i <= 1'b1;
    rdchk(IDX_PORT_CONFIG, 8'h04);
    @(posedge clk_sys_i);
    core_tx_busy_i <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rdchk(IDX_EVENT_STATUS, 8'h02);
    // Bank access denied until enabled
    @(posedge clk_sys_i);
    ext_bank_req_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(ext_bank_grant_o, 1'b0);
    rdchk(IDX_EVENT_STATUS, 8'h06);
    apb(1'b1, IDX_PORT_CONFIG, 8'h80);
    chk(ext_bank_grant_o, 1'b1);
    @(posedge clk_sys_i);
    ext_bank_req_i <= 1'b0;
    $display("busy and bank test done");
    // Inactive with float set releases the pins
    apb(1'b1, IDX_PORT_CONFIG, 8'h01);
    apb(1'b1, IDX_PORT_ACTIVATE, 8'h00);
    chk(pin_oe_o, 4'h0);
    chk(port_regs_access_o, 1'b0);
    $display("float test done");
    close_out();
  end
endmodule : test_serial_port_one_config
